// ### shared/loopseq_map.svh
// constants for the loop stack, re-entry freeze and fetch conflict logic
// assumes a 24-bit program address and 32-bit loop count
`ifndef LOOPSEQ_MAP_SVH
`define LOOPSEQ_MAP_SVH
`define ADDR_W 24
`define CNT_W 32
`define STK_DEPTH 6
`define STK_IDX_W 3
`define SHORT_BODY_MAX 24'h000003
`define SHORT_CNT_MAX 32'h00000003
`define FREEZE_CALL 3'h3
`define FREEZE_INT 3'h4
`define FREEZE_NONE 3'h0
`define HIDDEN_CLEAR 2'h0
`define ONE_CNT 32'h00000001
`endif

// ### shared/loopseq_pkg.sv
// types shared by the loop sequencer files
// assumes loopseq_map.svh is on the include path
`include "loopseq_map.svh"
package loopseq_pkg;
   // hidden marking kept beside each stack address
   typedef struct packed
   {
      logic by_loop;
      logic by_int;
   } hidden_t;
   typedef struct packed
   {
      logic [`ADDR_W-1:0] addr;
      hidden_t hid;
   } pc_entry_t;
   typedef struct packed
   {
      logic [`ADDR_W-1:0] end_addr;
      logic [`CNT_W-1:0] count;
      logic [`ADDR_W-1:0] start_addr;
   } loop_entry_t;
   typedef enum logic [2:0]
   {
      FZ_IDLE = 3'b001,
      FZ_CALL = 3'b010,
      FZ_INT = 3'b100
   } freeze_state_t;
endpackage

// ### logic/fetch_conflict.sv
// program-memory bus conflict detection and fetch stall
// assumes address-stage pm access and fetch1 request are same-cycle inputs
`timescale 1ns/1ps
`include "loopseq_map.svh"
module fetch_conflict
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic addr_pm_access_i,
   input wire logic fetch1_req_i,
   input wire logic cache_hit_i,
   input wire logic [`ADDR_W-1:0] fetch1_addr_i,
   output logic stall_o,
   output logic [`ADDR_W-1:0] fetch_addr_o
);
   logic [`ADDR_W-1:0] held_addr_r;
   logic [`ADDR_W-1:0] held_addr_nxt;
   logic stall_r;
   logic stall_nxt;
   always_comb
   begin
      // hit fetches run alongside the data access
      stall_nxt = addr_pm_access_i && fetch1_req_i && !cache_hit_i && !stall_r;
      held_addr_nxt = stall_nxt ? fetch1_addr_i : held_addr_r;
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stall_r <= 1'b0;
         held_addr_r <= '0;
      end
      else
      begin
         stall_r <= stall_nxt;
         held_addr_r <= held_addr_nxt;
      end
   end
   // data wins the bus; n+2 goes out one cycle later
   assign stall_o = stall_r;
   assign fetch_addr_o = stall_r ? held_addr_r : fetch1_addr_i;
endmodule

// ### logic/loop_sequencer.sv
// loop and pc stacks with hidden bits, short-loop classification,
// re-entry count freeze and fetch conflict stall
// assumes decoded strobes from the sequencer, one per cycle each
//
// Behaviour
// - re-entry return leaves the count unchanged for an end refetched inside the freeze
// - classify short loop at loop start and keep it throughout
// - classification not stacked; rebuilt from stack values on nesting
// - unrelated instructions may sit between push, count and end loads
// - end address write recomputes class from the loaded count
// - pc stack entries hold hidden bits set by interrupt entry or loop start hardware
// - software pc stack write clears the entry hidden bits
// - detect address-stage pm data access against fetch1 fetch
// - data access first, fetch n+2 delayed one stall cycle
// - stall only on cache miss; hits go without delay
// - decrement count when loop end instruction is in fetch1
// - subroutine return freezes the count for three fetches
// - interrupt return freezes count four fetches, flagged by hidden bit
`timescale 1ns/1ps
`include "loopseq_map.svh"
module loop_sequencer
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic LOOP_START_I,
   input wire logic [`ADDR_W-1:0] LOOP_START_ADDR_I,
   input wire logic [`ADDR_W-1:0] LOOP_END_ADDR_I,
   input wire logic [`CNT_W-1:0] LOOP_COUNT_INIT_I,
   input wire logic LOOP_PUSH_I,
   input wire logic LOOP_POP_I,
   input wire logic COUNT_WR_I,
   input wire logic END_WR_I,
   input wire logic [`CNT_W-1:0] WR_DATA_I,
   input wire logic CALL_I,
   input wire logic INT_ENTRY_I,
   input wire logic [`ADDR_W-1:0] RETURN_ADDR_I,
   input wire logic PC_PUSH_I,
   input wire logic PC_POP_I,
   input wire logic PC_WR_I,
   input wire logic RETURN_SUB_I,
   input wire logic RETURN_INT_I,
   input wire logic FETCH1_VALID_I,
   input wire logic [`ADDR_W-1:0] FETCH1_ADDR_I,
   input wire logic ADDR_PM_ACCESS_I,
   input wire logic CACHE_HIT_I,
   output logic [`ADDR_W-1:0] PC_STACK_TOP_O,
   output logic [`ADDR_W-1:0] LOOP_END_ADDRESS_TOP_O,
   output logic [`CNT_W-1:0] CURRENT_LOOP_COUNT_O,
   output logic LOOP_ACTIVE_O,
   output logic SHORT_LOOP_O,
   output logic LOOP_COUNT_EXPIRED_CONDITION_O,
   output logic COUNT_FROZEN_O,
   output logic FETCH_STALL_O,
   output logic [`ADDR_W-1:0] FETCH_ADDR_O
);
   loopseq_pkg::loop_entry_t lstk_r [`STK_DEPTH];
   loopseq_pkg::loop_entry_t lstk_nxt [`STK_DEPTH];
   loopseq_pkg::pc_entry_t pstk_r [`STK_DEPTH];
   loopseq_pkg::pc_entry_t pstk_nxt [`STK_DEPTH];
   logic [`STK_IDX_W-1:0] lsp_r;
   logic [`STK_IDX_W-1:0] lsp_nxt;
   logic [`STK_IDX_W-1:0] psp_r;
   logic [`STK_IDX_W-1:0] psp_nxt;
   logic short_r;
   logic short_nxt;
   loopseq_pkg::freeze_state_t fz_r;
   loopseq_pkg::freeze_state_t fz_nxt;
   logic [2:0] fz_cnt_r;
   logic [2:0] fz_cnt_nxt;
   logic [`STK_IDX_W-1:0] ltop;
   logic [`STK_IDX_W-1:0] ptop;
   logic [`STK_IDX_W-1:0] lnew;
   logic stall;
   logic fetch_step;
   logic frozen;

   // short means body of at most three with a small count
   function automatic logic is_short(input logic [`ADDR_W-1:0] s,
                                     input logic [`ADDR_W-1:0] e,
                                     input logic [`CNT_W-1:0] c);
      logic [`ADDR_W-1:0] len;
      len = e - s + 24'h000001;
      is_short = (len <= `SHORT_BODY_MAX) && (c <= `SHORT_CNT_MAX);
   endfunction

   assign ltop = lsp_r - 3'h1;
   assign ptop = psp_r - 3'h1;
   assign lnew = lsp_r - 3'h1 - 3'h1;
   assign fetch_step = FETCH1_VALID_I && !stall;
   assign frozen = (fz_r != loopseq_pkg::FZ_IDLE);

   always_comb
   begin
      lstk_nxt = lstk_r;
      lsp_nxt = lsp_r;
      short_nxt = short_r;
      if (LOOP_START_I && lsp_r < 3'(`STK_DEPTH))
      begin
         lstk_nxt[lsp_r].end_addr = LOOP_END_ADDR_I;
         lstk_nxt[lsp_r].count = LOOP_COUNT_INIT_I;
         lstk_nxt[lsp_r].start_addr = LOOP_START_ADDR_I;
         lsp_nxt = lsp_r + 3'h1;
         short_nxt = is_short(LOOP_START_ADDR_I, LOOP_END_ADDR_I, LOOP_COUNT_INIT_I);
      end
      else if (LOOP_PUSH_I && lsp_r < 3'(`STK_DEPTH))
      begin
         // restore path: count and end follow later, any gap allowed
         lstk_nxt[lsp_r] = '0;
         lstk_nxt[lsp_r].start_addr = FETCH1_ADDR_I;
         lsp_nxt = lsp_r + 3'h1;
      end
      else if (LOOP_POP_I && lsp_r != 3'h0)
      begin
         lsp_nxt = lsp_r - 3'h1;
         // outer loop class rebuilt from what the stack still holds
         if (lsp_r > 3'h1)
            short_nxt = is_short(lstk_r[lnew].start_addr, lstk_r[lnew].end_addr,
                                 lstk_r[lnew].count);
         else
            short_nxt = 1'b0;
      end
      else if (lsp_r != 3'h0)
      begin
         if (COUNT_WR_I)
            lstk_nxt[ltop].count = WR_DATA_I;
         if (END_WR_I)
         begin
            lstk_nxt[ltop].end_addr = WR_DATA_I[`ADDR_W-1:0];
            // uses count loaded before, hence the count-then-end order
            short_nxt = is_short(lstk_r[ltop].start_addr, WR_DATA_I[`ADDR_W-1:0],
                                 lstk_r[ltop].count);
         end
         if (!COUNT_WR_I && fetch_step && !frozen &&
             FETCH1_ADDR_I == lstk_r[ltop].end_addr &&
             lstk_r[ltop].count != `CNT_W'(0))
            lstk_nxt[ltop].count = lstk_r[ltop].count - `ONE_CNT;
      end
   end

   always_comb
   begin
      pstk_nxt = pstk_r;
      psp_nxt = psp_r;
      if ((CALL_I || INT_ENTRY_I || LOOP_START_I || PC_PUSH_I) && psp_r < 3'(`STK_DEPTH))
      begin
         pstk_nxt[psp_r].addr = LOOP_START_I ? LOOP_START_ADDR_I : RETURN_ADDR_I;
         pstk_nxt[psp_r].hid.by_loop = LOOP_START_I;
         pstk_nxt[psp_r].hid.by_int = INT_ENTRY_I;
         psp_nxt = psp_r + 3'h1;
      end
      else if ((PC_POP_I || RETURN_SUB_I || RETURN_INT_I) && psp_r != 3'h0)
         psp_nxt = psp_r - 3'h1;
      else if (PC_WR_I && psp_r != 3'h0)
      begin
         pstk_nxt[ptop].addr = WR_DATA_I[`ADDR_W-1:0];
         pstk_nxt[ptop].hid = `HIDDEN_CLEAR;
      end
   end

   // freeze length chosen from the return kind and the hidden bit
   always_comb
   begin
      fz_nxt = fz_r;
      fz_cnt_nxt = fz_cnt_r;
      unique case (fz_r)
         loopseq_pkg::FZ_IDLE:
         begin
            if ((RETURN_SUB_I || RETURN_INT_I) && psp_r != 3'h0)
            begin
               if (RETURN_INT_I || pstk_r[ptop].hid.by_int)
               begin
                  fz_nxt = loopseq_pkg::FZ_INT;
                  fz_cnt_nxt = `FREEZE_INT;
               end
               else
               begin
                  fz_nxt = loopseq_pkg::FZ_CALL;
                  fz_cnt_nxt = `FREEZE_CALL;
               end
            end
         end
         loopseq_pkg::FZ_CALL, loopseq_pkg::FZ_INT:
         begin
            if (fetch_step)
            begin
               fz_cnt_nxt = fz_cnt_r - 3'h1;
               if (fz_cnt_r == 3'h1)
                  fz_nxt = loopseq_pkg::FZ_IDLE;
            end
         end
         default:
         begin
            fz_nxt = loopseq_pkg::FZ_IDLE;
            fz_cnt_nxt = `FREEZE_NONE;
         end
      endcase
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         for (int i = 0; i < `STK_DEPTH; i++)
         begin
            lstk_r[i] <= '0;
            pstk_r[i] <= '0;
         end
         lsp_r <= '0;
         psp_r <= '0;
         short_r <= 1'b0;
         fz_r <= loopseq_pkg::FZ_IDLE;
         fz_cnt_r <= `FREEZE_NONE;
      end
      else
      begin
         lstk_r <= lstk_nxt;
         pstk_r <= pstk_nxt;
         lsp_r <= lsp_nxt;
         psp_r <= psp_nxt;
         short_r <= short_nxt;
         fz_r <= fz_nxt;
         fz_cnt_r <= fz_cnt_nxt;
      end
   end

   fetch_conflict u_conflict
   (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .addr_pm_access_i(ADDR_PM_ACCESS_I),
      .fetch1_req_i(FETCH1_VALID_I),
      .cache_hit_i(CACHE_HIT_I),
      .fetch1_addr_i(FETCH1_ADDR_I),
      .stall_o(stall),
      .fetch_addr_o(FETCH_ADDR_O)
   );

   // top views are plain reads of the stack flops
   assign PC_STACK_TOP_O = (psp_r != 3'h0) ? pstk_r[ptop].addr : '0;
   assign LOOP_END_ADDRESS_TOP_O = (lsp_r != 3'h0) ? lstk_r[ltop].end_addr : '0;
   assign CURRENT_LOOP_COUNT_O = (lsp_r != 3'h0) ? lstk_r[ltop].count : '0;
   assign LOOP_ACTIVE_O = (lsp_r != 3'h0);
   assign SHORT_LOOP_O = short_r;
   assign LOOP_COUNT_EXPIRED_CONDITION_O = (lsp_r != 3'h0) && (lstk_r[ltop].count == `ONE_CNT);
   assign COUNT_FROZEN_O = frozen;
   assign FETCH_STALL_O = stall;
endmodule

// ### sim/loop_sequencer_checker.sv
// port-level checks on the loop sequencer
// assumes binding into loop_sequencer; one clock, async high reset
`timescale 1ns/1ps
`include "loopseq_map.svh"
module loop_sequencer_checker
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic LOOP_START_I,
   input wire logic LOOP_PUSH_I,
   input wire logic LOOP_POP_I,
   input wire logic COUNT_WR_I,
   input wire logic FETCH1_VALID_I,
   input wire logic [`ADDR_W-1:0] FETCH1_ADDR_I,
   input wire logic ADDR_PM_ACCESS_I,
   input wire logic CACHE_HIT_I,
   input wire logic [`ADDR_W-1:0] LOOP_END_ADDRESS_TOP_O,
   input wire logic [`CNT_W-1:0] CURRENT_LOOP_COUNT_O,
   input wire logic LOOP_ACTIVE_O,
   input wire logic COUNT_FROZEN_O,
   input wire logic FETCH_STALL_O,
   input wire logic [`ADDR_W-1:0] FETCH_ADDR_O
);
   logic quiet;
   logic miss;
   logic [2:0] fz_cnt_r;
   logic [2:0] fz_cnt_nxt;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   always_comb
   begin
      quiet = !(LOOP_START_I || LOOP_PUSH_I || LOOP_POP_I || COUNT_WR_I || ADDR_PM_ACCESS_I);
      miss = ADDR_PM_ACCESS_I && FETCH1_VALID_I && !CACHE_HIT_I;
      // counts fetch steps seen while frozen; stalled cycles are no step
      fz_cnt_nxt = COUNT_FROZEN_O ? fz_cnt_r + {2'h0, FETCH1_VALID_I && !FETCH_STALL_O} : 3'h0;
   end
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         fz_cnt_r <= 3'h0;
      else
         fz_cnt_r <= fz_cnt_nxt;
   end
   sequence end_fetch_s;
      quiet && FETCH1_VALID_I && !FETCH_STALL_O && !COUNT_FROZEN_O && LOOP_ACTIVE_O &&
         FETCH1_ADDR_I == LOOP_END_ADDRESS_TOP_O && CURRENT_LOOP_COUNT_O > `ONE_CNT;
   endsequence
   sequence stall_s;
      miss && !FETCH_STALL_O ##1 FETCH_STALL_O;
   endsequence
   stall_on_miss_a: assert property (miss && !FETCH_STALL_O |=> FETCH_STALL_O)
      else $error("stall missing after conflict");
   stall_addr_a: assert property (stall_s |-> FETCH_ADDR_O == $past(FETCH1_ADDR_I))
      else $error("fetch address not held in stall");
   stall_cause_a: assert property (FETCH_STALL_O |-> $past(miss))
      else $error("stall without uncached conflict");
   stall_once_a: assert property (FETCH_STALL_O |=> !FETCH_STALL_O)
      else $error("stall longer than one cycle");
   addr_pass_a: assert property (!FETCH_STALL_O |-> FETCH_ADDR_O == FETCH1_ADDR_I)
      else $error("fetch address not passed through");
   count_dec_a: assert property (end_fetch_s |=> CURRENT_LOOP_COUNT_O == $past(CURRENT_LOOP_COUNT_O) - `ONE_CNT)
      else $error("count not decremented once");
   frozen_hold_a: assert property (COUNT_FROZEN_O && quiet |=> $stable(CURRENT_LOOP_COUNT_O))
      else $error("count moved while frozen");
   freeze_max_a: assert property (COUNT_FROZEN_O |-> fz_cnt_r <= 3'h4)
      else $error("freeze over four fetches");
   freeze_min_a: assert property ($fell(COUNT_FROZEN_O) |-> fz_cnt_r >= 3'h3)
      else $error("freeze under three fetches");
endmodule
bind loop_sequencer loop_sequencer_checker chk_u (.*);

// ### sim/fetch_model.sv
// program-memory fetch side feeding the fetch1 stage
// assumes stall_i is the one-cycle registered stall of the sequencer
`timescale 1ns/1ps
`include "loopseq_map.svh"
module fetch_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ld_i,
   input wire logic [`ADDR_W-1:0] ld_addr_i,
   input wire logic go_i,
   input wire logic stall_i,
   output logic valid_o,
   output logic [`ADDR_W-1:0] addr_o
);
   logic [`ADDR_W-1:0] addr_r;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         addr_r <= 24'h0;
      else if (ld_i)
         addr_r <= ld_addr_i;
      else if (go_i && !stall_i)
         addr_r <= addr_r + 24'h1;
   end
   // idle bus shows the inverse, never a stale copy
   assign valid_o = go_i;
   assign addr_o = go_i ? addr_r : ~addr_r;
endmodule

// ### sim/tb_top.sv
// self-checking bench for the loop sequencer
// assumes fetch_model on the fetch side and the bound checker
`timescale 1ns/1ps
`include "loopseq_map.svh"
module tb_top;
   logic CLK_I = 1'b0, RST_I = 1'b1, LOOP_START_I = 1'b0, LOOP_PUSH_I = 1'b0, LOOP_POP_I = 1'b0;
   logic COUNT_WR_I = 1'b0, END_WR_I = 1'b0, CALL_I = 1'b0, INT_ENTRY_I = 1'b0, PC_PUSH_I = 1'b0;
   logic PC_POP_I = 1'b0, PC_WR_I = 1'b0, RETURN_SUB_I = 1'b0, RETURN_INT_I = 1'b0;
   logic ADDR_PM_ACCESS_I = 1'b0, CACHE_HIT_I = 1'b0, ld = 1'b0, go = 1'b0, FETCH1_VALID_I;
   logic LOOP_ACTIVE_O, SHORT_LOOP_O, LOOP_COUNT_EXPIRED_CONDITION_O, COUNT_FROZEN_O, FETCH_STALL_O;
   logic [`ADDR_W-1:0] LOOP_START_ADDR_I = 24'h0, LOOP_END_ADDR_I = 24'h0, RETURN_ADDR_I = 24'h0;
   logic [`ADDR_W-1:0] ld_addr = 24'h0, FETCH1_ADDR_I, PC_STACK_TOP_O, LOOP_END_ADDRESS_TOP_O;
   logic [`ADDR_W-1:0] FETCH_ADDR_O;
   logic [`CNT_W-1:0] LOOP_COUNT_INIT_I = 32'h0, WR_DATA_I = 32'h0, CURRENT_LOOP_COUNT_O;
   int n_errors = 0;
   int total_checks = 0;
   loop_sequencer dut_u (.*);
   fetch_model model_u (.clk_i(CLK_I), .rst_i(RST_I), .ld_i(ld), .ld_addr_i(ld_addr), .go_i(go),
      .stall_i(FETCH_STALL_O), .valid_o(FETCH1_VALID_I), .addr_o(FETCH1_ADDR_I));
   always #2 CLK_I = ~CLK_I;
   task automatic tick(input int n = 1);
      repeat (n) @(posedge CLK_I);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic run_fetch(input logic [23:0] a, input int n);
      ld = 1'b1;
      ld_addr = a;
      tick();
      ld = 1'b0;
      go = 1'b1;
      tick(n);
      go = 1'b0;
   endtask
   task automatic start_loop(input logic [23:0] s, input logic [23:0] e, input logic [31:0] c);
      LOOP_START_I = 1'b1;
      LOOP_START_ADDR_I = s;
      LOOP_END_ADDR_I = e;
      LOOP_COUNT_INIT_I = c;
      tick();
      LOOP_START_I = 1'b0;
   endtask
   task automatic t_conflict;
      ADDR_PM_ACCESS_I = 1'b1;
      run_fetch(24'h000300, 1);
      chk(FETCH_STALL_O, 1'b1);
      chk(FETCH_ADDR_O, 32'h300);
      tick();
      chk(FETCH_STALL_O, 1'b0);
      // a fresh conflict cycle, so only the hit can keep the stall away
      CACHE_HIT_I = 1'b1;
      go = 1'b1;
      tick();
      chk(FETCH_STALL_O, 1'b0);
      ADDR_PM_ACCESS_I = 1'b0;
      CACHE_HIT_I = 1'b0;
      go = 1'b0;
   endtask
   task automatic t_class;
      start_loop(24'h000100, 24'h000102, 32'h2);
      chk(SHORT_LOOP_O, 1'b1);
      tick();
      start_loop(24'h000110, 24'h000113, 32'h2);
      chk(SHORT_LOOP_O, 1'b0);
      LOOP_POP_I = 1'b1;
      PC_POP_I = 1'b1;
      tick();
      LOOP_POP_I = 1'b0;
      PC_POP_I = 1'b0;
      chk(SHORT_LOOP_O, 1'b1);
      chk(LOOP_END_ADDRESS_TOP_O, 32'h102);
      run_fetch(24'h000102, 1);
      chk(CURRENT_LOOP_COUNT_O, 32'h1);
      chk(LOOP_COUNT_EXPIRED_CONDITION_O, 1'b1);
   endtask
   // call, interrupt, interrupt left by plain return, and a pc write that drops the mark
   task automatic t_freeze;
      start_loop(24'h000400, 24'h00040f, 32'h8);
      for (int k = 0; k < 4; k++)
      begin
         CALL_I = (k == 0);
         INT_ENTRY_I = (k != 0);
         RETURN_ADDR_I = 24'h000405;
         tick();
         CALL_I = 1'b0;
         INT_ENTRY_I = 1'b0;
         PC_WR_I = (k == 3);
         WR_DATA_I = 32'h345;
         tick();
         PC_WR_I = 1'b0;
         chk(PC_STACK_TOP_O, (k == 3) ? 32'h345 : 32'h405);
         RETURN_SUB_I = (k != 1);
         RETURN_INT_I = (k == 1);
         tick();
         RETURN_SUB_I = 1'b0;
         RETURN_INT_I = 1'b0;
         chk(COUNT_FROZEN_O, 1'b1);
         run_fetch((k == 1 || k == 2) ? 24'h00040c : 24'h00040d, (k == 1 || k == 2) ? 4 : 3);
         chk(CURRENT_LOOP_COUNT_O, 32'h8 - k);
         run_fetch(24'h00040f, 1);
         chk(CURRENT_LOOP_COUNT_O, 32'h7 - k);
      end
   endtask
   task automatic t_restore;
      for (int k = 0; k < 2; k++)
      begin
         LOOP_POP_I = 1'b1;
         PC_POP_I = 1'b1;
         run_fetch(24'h000200, 1);
         LOOP_POP_I = 1'b0;
         PC_POP_I = 1'b0;
         chk(LOOP_ACTIVE_O, 1'b0);
         LOOP_PUSH_I = 1'b1;
         run_fetch(24'h000200, 1);
         LOOP_PUSH_I = 1'b0;
         COUNT_WR_I = 1'b1;
         WR_DATA_I = (k == 0) ? 32'h2 : 32'h9;
         tick(2);
         COUNT_WR_I = 1'b0;
         tick(3);
         END_WR_I = 1'b1;
         WR_DATA_I = 32'h201;
         tick();
         END_WR_I = 1'b0;
         chk(SHORT_LOOP_O, k == 0);
         chk(LOOP_END_ADDRESS_TOP_O, 32'h201);
         chk(CURRENT_LOOP_COUNT_O, (k == 0) ? 32'h2 : 32'h9);
         chk(LOOP_ACTIVE_O, 1'b1);
         // pc stack comes back last, then its top is loaded
         PC_PUSH_I = 1'b1;
         RETURN_ADDR_I = 24'h0003e0;
         tick();
         PC_PUSH_I = 1'b0;
         chk(PC_STACK_TOP_O, 32'h3e0);
         PC_WR_I = 1'b1;
         WR_DATA_I = 32'h3e1;
         tick();
         PC_WR_I = 1'b0;
         chk(PC_STACK_TOP_O, 32'h3e1);
      end
   endtask
   // mid-run reset must empty both stacks
   task automatic t_reset;
      RST_I = 1'b1;
      tick(2);
      RST_I = 1'b0;
      chk(LOOP_ACTIVE_O, 1'b0);
      chk(PC_STACK_TOP_O, 32'h0);
      chk(CURRENT_LOOP_COUNT_O, 32'h0);
   endtask
   initial
   begin
      tick(6);
      RST_I = 1'b0;
      chk(CURRENT_LOOP_COUNT_O, 32'h0);
      t_conflict;
      t_class;
      t_freeze;
      t_restore;
      t_reset;
      wrap_up;
   end
   initial
   begin
      #100000;
      n_errors++;
      wrap_up;
   end
endmodule
